// ### include/adc_acc_pkg.sv
// Package: register map, field layout and carriers for the sample accumulator
package adc_acc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Avalon-MM slave)
    // ------------------------------------------------------------
    localparam int unsigned TABLE_ENTRIES = 32;
    localparam logic [7:0] OFF_TABLE_BASE = 8'h00;
    localparam logic [7:0] OFF_CTRL_HIGH = 8'h80;
    localparam logic [7:0] OFF_CTRL_LOW = 8'h84;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h88;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h8C;
    localparam logic [7:0] OFF_RESULT = 8'h90;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned TBL_CHARGE_TIME_UNIT_BIT = 15;
    localparam int unsigned TBL_PAIRED_INPUT_SELECT_BIT = 14;
    localparam int unsigned TBL_CH_LSB = 0;
    localparam int unsigned TBL_CH_W = 7;
    localparam int unsigned CTRLH_ACCUMULATE_ENABLE_BIT = 7;
    localparam int unsigned CTRLH_ACCUMULATOR_IRQ_ENABLE_BIT = 6;
    localparam int unsigned CTRLL_SEL_LSB = 8;
    localparam int unsigned CTRLL_SEL_W = 6;
    localparam int unsigned CTRLL_CNT_LSB = 0;
    localparam int unsigned CTRLL_CNT_W = 8;
    localparam int unsigned IRQ_DONE_BIT = 0;

    // Writable masks; everything else reads as zero
    localparam logic [15:0] TBL_WMASK = 16'hC07F;
    localparam logic [15:0] CTRLH_WMASK = 16'h00C0;
    localparam logic [15:0] CTRLL_WMASK = 16'h3FFF;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic charge_time_unit_enable;
        logic paired_input_select;
        logic [6:0] channel_select_code;
    } conv_req_s;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avm_req_s;

endpackage

// ### logic/adc_sample_accumulator.sv
// Accumulator sequencing, sample table and register slave for the converter
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module adc_sample_accumulator
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Converter core
    input wire logic conv_trigger,
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    output logic conv_start,
    output adc_acc_pkg::conv_req_s conv_req,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum {
        ST_IDLE,
        ST_WAIT_TRIG,
        ST_CONVERT
    } acc_state_e;

    typedef struct packed {
        // Registers software sees
        logic [31:0][15:0] table_reg;
        logic accumulate_enable;
        logic accumulator_irq_enable;
        logic [5:0] sel;
        logic [7:0] count;
        // Accumulator
        logic first;
        logic [31:0] result;
        // Interrupt
        logic status;
        logic mask;
        // Bus answer
        logic [31:0] rdata;
        logic waitreq;
        // Converter request, interrupt line and sequencer
        logic start;
        adc_acc_pkg::conv_req_s req;
        logic irq;
        logic [1:0] state;
    } acc_state_s;

    acc_state_s st_r;
    acc_state_s st_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Merge write data by byte lane and writable mask
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be, input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}};
        merge16 = ((old & ~(lanes & wmask)) | (wd[15:0] & lanes & wmask));
    endfunction

    function automatic adc_acc_pkg::conv_req_s entry_req(input logic [15:0] entry);
        adc_acc_pkg::conv_req_s r;
        r.charge_time_unit_enable = entry[adc_acc_pkg::TBL_CHARGE_TIME_UNIT_BIT];
        r.paired_input_select = entry[adc_acc_pkg::TBL_PAIRED_INPUT_SELECT_BIT];
        r.channel_select_code = entry[adc_acc_pkg::TBL_CH_LSB +: adc_acc_pkg::TBL_CH_W];
        entry_req = r;
    endfunction

    function automatic logic [1:0] enc(input acc_state_e s);
        enc = 2'(s);
    endfunction

    // High control word as software sees it; unused bits stay zero
    function automatic logic [15:0] ctrl_high_word(input logic accumulate_enable, input logic accumulator_irq_enable);
        logic [15:0] w;
        w = 16'h0000;
        w[adc_acc_pkg::CTRLH_ACCUMULATE_ENABLE_BIT] = accumulate_enable;
        w[adc_acc_pkg::CTRLH_ACCUMULATOR_IRQ_ENABLE_BIT] = accumulator_irq_enable;
        ctrl_high_word = w;
    endfunction

    // Low control word; bits 15 and 14 are not stored and read as zero
    function automatic logic [15:0] ctrl_low_word(input logic [5:0] sel, input logic [7:0] count);
        logic [15:0] w;
        w = 16'h0000;
        w[adc_acc_pkg::CTRLL_SEL_LSB +: adc_acc_pkg::CTRLL_SEL_W] = sel;
        w[adc_acc_pkg::CTRLL_CNT_LSB +: adc_acc_pkg::CTRLL_CNT_W] = count;
        ctrl_low_word = w;
    endfunction

    // Table entries fill the space below the high control register
    function automatic logic is_table(input logic [7:0] addr);
        is_table = (addr < adc_acc_pkg::OFF_CTRL_HIGH);
    endfunction

    function automatic logic [4:0] table_index(input logic [7:0] addr);
        table_index = addr[6:2];
    endfunction

    // Samples are unsigned; 256 full-scale samples still fit well inside the sum
    function automatic logic [31:0] add_sample(input logic [31:0] sum, input logic [15:0] sample);
        add_sample = sum + {16'h0000, sample};
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic access;
        logic [7:0] a;
        logic [15:0] ctrl_h;
        logic [15:0] ctrl_l;
        logic [15:0] entry;
        logic [31:0] base;
        logic hw_done;
        logic done_evt;
        st_nxt = st_r;
        access = (avs_read || avs_write) && st_r.waitreq;
        a = avs_address;
        ctrl_h = ctrl_high_word(st_r.accumulate_enable, st_r.accumulator_irq_enable);
        ctrl_l = ctrl_low_word(st_r.sel, st_r.count);
        // Only 32 entries exist, so the pointer's top bit aliases onto the lower half
        entry = st_r.table_reg[st_r.sel[4:0]];
        base = st_r.first ? adc_acc_pkg::RESULT_RESET : st_r.result;
        hw_done = 1'b0;
        done_evt = 1'b0;
        st_nxt.waitreq = !access;
        st_nxt.rdata = adc_acc_pkg::UNMAPPED_READ;
        st_nxt.start = 1'b0;

        // --------------------------------------------------------
        // Sequencer: one trigger, one conversion, one add
        // --------------------------------------------------------
        case (st_r.state)
            enc(ST_IDLE):
            begin
                if (st_r.accumulate_enable)
                begin
                    st_nxt.state = enc(ST_WAIT_TRIG);
                end
            end
            enc(ST_WAIT_TRIG):
            begin
                // Triggers outside this state are ignored, so a conversion in flight is never doubled
                if (!st_r.accumulate_enable)
                begin
                    st_nxt.state = enc(ST_IDLE);
                end
                else if (conv_trigger)
                begin
                    st_nxt.req = entry_req(entry);
                    st_nxt.start = 1'b1;
                    st_nxt.state = enc(ST_CONVERT);
                end
            end
            enc(ST_CONVERT):
            begin
                if (conv_done)
                begin
                    // First sample replaces the sum so each run starts clean
                    st_nxt.result = add_sample(base, conv_result);
                    st_nxt.first = 1'b0;
                    // A count of zero wraps to 255 here, so such a run takes 256 samples
                    st_nxt.count = st_r.count - 8'h01;
                    if (st_r.count == 8'h01)
                    begin
                        hw_done = 1'b1;
                        st_nxt.accumulate_enable = 1'b0;
                        done_evt = st_r.accumulator_irq_enable;
                        st_nxt.state = enc(ST_IDLE);
                    end
                    else
                    begin
                        st_nxt.state = enc(ST_WAIT_TRIG);
                    end
                end
            end
            default:
            begin
                st_nxt.state = enc(ST_IDLE);
            end
        endcase

        // --------------------------------------------------------
        // Register reads
        // --------------------------------------------------------
        if (access && avs_read)
        begin
            if (is_table(a))
            begin
                st_nxt.rdata = {16'h0000, st_r.table_reg[table_index(a)]};
            end
            else
            begin
                case (a)
                    adc_acc_pkg::OFF_CTRL_HIGH:
                    begin
                        st_nxt.rdata = {16'h0000, ctrl_h};
                    end
                    adc_acc_pkg::OFF_CTRL_LOW:
                    begin
                        st_nxt.rdata = {16'h0000, ctrl_l};
                    end
                    adc_acc_pkg::OFF_IRQ_STATUS:
                    begin
                        st_nxt.rdata = {31'h0, st_r.status};
                    end
                    adc_acc_pkg::OFF_IRQ_MASK:
                    begin
                        st_nxt.rdata = {31'h0, st_r.mask};
                    end
                    adc_acc_pkg::OFF_RESULT:
                    begin
                        st_nxt.rdata = st_r.result;
                    end
                    default:
                    begin
                        st_nxt.rdata = adc_acc_pkg::UNMAPPED_READ;
                    end
                endcase
            end
        end

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        // Writes during accumulation are taken as given; keeping them out is up to software
        if (access && avs_write)
        begin
            if (is_table(a))
            begin
                st_nxt.table_reg[table_index(a)] = merge16(st_r.table_reg[table_index(a)], avs_writedata,
                                                           avs_byteenable, adc_acc_pkg::TBL_WMASK);
            end
            else
            begin
                case (a)
                    adc_acc_pkg::OFF_CTRL_HIGH:
                    begin
                        ctrl_h = merge16(ctrl_h, avs_writedata, avs_byteenable, adc_acc_pkg::CTRLH_WMASK);
                        if (ctrl_h[adc_acc_pkg::CTRLH_ACCUMULATE_ENABLE_BIT] && !st_r.accumulate_enable)
                        begin
                            st_nxt.first = 1'b1;
                        end
                        // Completion in the same cycle wins over a software set
                        st_nxt.accumulate_enable = ctrl_h[adc_acc_pkg::CTRLH_ACCUMULATE_ENABLE_BIT] && !hw_done;
                        st_nxt.accumulator_irq_enable = ctrl_h[adc_acc_pkg::CTRLH_ACCUMULATOR_IRQ_ENABLE_BIT];
                    end
                    adc_acc_pkg::OFF_CTRL_LOW:
                    begin
                        ctrl_l = merge16(ctrl_l, avs_writedata, avs_byteenable, adc_acc_pkg::CTRLL_WMASK);
                        st_nxt.sel = ctrl_l[adc_acc_pkg::CTRLL_SEL_LSB +: adc_acc_pkg::CTRLL_SEL_W];
                        st_nxt.count = ctrl_l[adc_acc_pkg::CTRLL_CNT_LSB +: adc_acc_pkg::CTRLL_CNT_W];
                    end
                    adc_acc_pkg::OFF_IRQ_STATUS:
                    begin
                        // Write one to clear
                        if (avs_byteenable[0] && avs_writedata[adc_acc_pkg::IRQ_DONE_BIT])
                        begin
                            st_nxt.status = 1'b0;
                        end
                    end
                    adc_acc_pkg::OFF_IRQ_MASK:
                    begin
                        if (avs_byteenable[0])
                        begin
                            st_nxt.mask = avs_writedata[adc_acc_pkg::IRQ_DONE_BIT];
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end

        // --------------------------------------------------------
        // Interrupt
        // --------------------------------------------------------
        // Set wins over a same-cycle clear
        if (done_evt)
        begin
            st_nxt.status = 1'b1;
        end
        // Taken from the next state so the line follows status and mask with no extra cycle
        st_nxt.irq = st_nxt.status && st_nxt.mask;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            // Waitrequest rests high in reset so no answer shows before a request
            st_r <= '{waitreq: 1'b1, default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Waitrequest drops in the cycle after the request is seen
    assign avs_waitrequest = st_r.waitreq;
    assign avs_readdata = st_r.rdata;
    assign conv_start = st_r.start;
    assign conv_req = st_r.req;
    assign irq = st_r.irq;

endmodule

// ### testbench/adc_sample_accumulator_properties.sv
// Checker: port-level properties of the sample accumulator
`timescale 1ns/100ps

module adc_sample_accumulator_properties
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Converter and interrupt
    input wire logic conv_trigger,
    input wire logic conv_done,
    input wire logic conv_start,
    input wire adc_acc_pkg::conv_req_s conv_req,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    AST_START_AFTER_TRIG: assert property (conv_start |-> $past(conv_trigger))
        else $error("conversion start without a trigger");
    AST_START_PULSE: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    AST_REQ_HELD: assert property (!conv_start |-> $stable(conv_req))
        else $error("conversion request changed without a start");
    AST_ACK_ONE: assert property (avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");
    AST_ACK_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer longer than one cycle");
    AST_NO_SPURIOUS: assert property (avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
        else $error("bus answer without a request");
    AST_CTRLH_ZERO: assert property (!avs_waitrequest && avs_read && avs_address == 8'h80
        |-> (avs_readdata & 32'hFFFF_FF3F) == 32'h0000_0000)
        else $error("unused high control bits not zero");
    AST_CTRLL_ZERO: assert property (!avs_waitrequest && avs_read && avs_address == 8'h84
        |-> avs_readdata[31:14] == 18'h00000)
        else $error("unused low control bits not zero");
    AST_TABLE_ZERO: assert property (!avs_waitrequest && avs_read && !avs_address[7]
        |-> (avs_readdata & 32'hFFFF_3F80) == 32'h0000_0000)
        else $error("unused table entry bits not zero");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(conv_done) || $past(avs_write))
        else $error("interrupt rose without a cause");

    C_START: cover property (conv_start);
    C_IRQ: cover property ($rose(irq));
    C_CTRL_READ: cover property (!avs_waitrequest && avs_read && avs_address == 8'h84);
endmodule

bind adc_sample_accumulator adc_sample_accumulator_properties u_props (.mclk(mclk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_trigger(conv_trigger), .conv_done(conv_done),
    .conv_start(conv_start), .conv_req(conv_req), .irq(irq));

// ### testbench/adc_sample_accumulator_test.sv
// Testbench: register and accumulation sequences for the sample accumulator
`timescale 1ns/100ps

module adc_sample_accumulator_test;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h3;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic conv_trigger = 1'b0;
    logic conv_done = 1'b0;
    logic [15:0] conv_result = 16'h0000;
    logic conv_start;
    logic irq;
    adc_acc_pkg::conv_req_s conv_req;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;

    adc_sample_accumulator dut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .conv_trigger(conv_trigger), .conv_done(conv_done), .conv_result(conv_result),
        .conv_start(conv_start), .conv_req(conv_req), .irq(irq));

    always #5 mclk = ~mclk;

    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Both tasks let one edge pass at the end so a next request never lands in the same step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        chk(nm, e, avs_readdata);
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic conv(input logic [15:0] r, input logic [8:0] req);
        conv_trigger <= 1'b1;
        @(posedge mclk);
        conv_trigger <= 1'b0;
        do @(posedge mclk); while (conv_start !== 1'b1);
        chk("conv_req", {23'h0, req}, {23'h0, conv_req});
        conv_result <= r;
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // --------------------------------------------------------
    // Sequence
    // --------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rchk("ctrl_high", 8'h80, 32'h0);
        rchk("ctrl_low", 8'h84, 32'h0);
        rchk("unmapped", 8'hA0, 32'h0);
        wr(8'h0C, 16'hFFFF);
        rchk("entry3", 8'h0C, 32'h0000_C07F);
        wr(8'h84, 16'hFFFF);
        rchk("ctrl_low_mask", 8'h84, 32'h0000_3FFF);
        $display("test registers done");

        // Count loaded before enabling; control is left alone while enabled
        wr(8'h84, 16'h0303);
        wr(8'h8C, 16'h0001);
        wr(8'h80, 16'h00C0);
        conv(16'h0001, 9'h1FF);
        rchk("count_2", 8'h84, 32'h0000_0302);
        conv(16'h0002, 9'h1FF);
        chk("irq_early", 32'h0, {31'h0, irq});
        conv(16'h0003, 9'h1FF);
        rchk("accumulate_enable_clear", 8'h80, 32'h0000_0040);
        rchk("sum", 8'h90, 32'h0000_0006);
        rchk("status", 8'h88, 32'h0000_0001);
        chk("irq_set", 32'h1, {31'h0, irq});
        wr(8'h88, 16'h0001);
        repeat (2) @(posedge mclk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        $display("test short accumulation done");

        wr(8'h14, 16'h4012);
        wr(8'h84, 16'h0500);
        wr(8'h80, 16'h0080);
        repeat (255) conv(16'h0001, 9'h092);
        rchk("accumulate_enable_255", 8'h80, 32'h0000_0080);
        rchk("count_1", 8'h84, 32'h0000_0501);
        conv(16'h0001, 9'h092);
        rchk("accumulate_enable_256", 8'h80, 32'h0000_0000);
        rchk("sum_256", 8'h90, 32'h0000_0100);
        rchk("status_off", 8'h88, 32'h0000_0000);
        chk("irq_off", 32'h0, {31'h0, irq});
        $display("test full accumulation done");

        // Reset in mid-run, then a masked single-sample run on a single-ended entry
        wr(8'h84, 16'h0007);
        wr(8'h80, 16'h0080);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rchk("ctrl_high_rst", 8'h80, 32'h0);
        rchk("ctrl_low_rst", 8'h84, 32'h0);
        rchk("entry3_rst", 8'h0C, 32'h0);
        conv_trigger <= 1'b1;
        repeat (3)
        begin
            @(posedge mclk);
            chk("no_start_off", 32'h0, {31'h0, conv_start});
        end
        conv_trigger <= 1'b0;
        wr(8'h0C, 16'h8005);
        wr(8'h84, 16'h0301);
        wr(8'h80, 16'h00C0);
        conv(16'h1234, 9'h105);
        rchk("accumulate_enable_one", 8'h80, 32'h0000_0040);
        rchk("sum_one", 8'h90, 32'h0000_1234);
        rchk("status_masked", 8'h88, 32'h0000_0001);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(8'h8C, 16'h0001);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        $display("test reset and masking done");
        report_and_stop();
    end
endmodule
